// File: include/usbse_defs.vh
// register map, field positions and reset values of the status and endpoint enable block
`ifndef USBSE_DEFS_VH
`define USBSE_DEFS_VH

// register byte addresses
`define USBSE_ADDR_IN_EN 32'h4001104C
`define USBSE_ADDR_OUT_EN 32'h40011050
`define USBSE_ADDR_STATUS 32'h4001106C
`define USBSE_ADDR_INTF1 32'h40011074
`define USBSE_ADDR_IRQ_STAT 32'h40011080
`define USBSE_ADDR_IRQ_MASK 32'h40011084

// reset values
`define USBSE_RST_IN_EN 32'h00000001
`define USBSE_RST_OUT_EN 32'h00000001
`define USBSE_RST_STATUS 32'h00000000
`define USBSE_RST_INTF1 32'h00000000
`define USBSE_RST_IRQ 2'h0

// status register fields
`define USBSE_ST_RESET_BIT 12
`define USBSE_ST_SLEEP_BIT 11
`define USBSE_ST_TS_MSB 10
`define USBSE_ST_TS_LSB 0

// endpoint enable and interface fields
`define USBSE_EP_MSB 6
`define USBSE_EP_FIRST 1
`define USBSE_EP0_BIT 0
`define USBSE_INTF1_GATE_BIT 31

// interrupt status and mask fields
`define USBSE_IRQ_RESET_BIT 0
`define USBSE_IRQ_SLEEP_BIT 1

`endif

// File: rtl/usbse_edge.v
// two-stage synchroniser with a registered rising-edge pulse
`timescale 1ns/1ns
module usbse_edge
(
    // clock and reset
    input wire clk,
    input wire resetn,
    // asynchronous level in
    input wire level_in,
    // synchronised level and rise pulse
    output reg level_ff,
    output reg rise_ff
);

reg meta_ff;
reg last_ff;

always @(posedge clk)
begin
    if (!resetn)
    begin
        meta_ff <= 1'b0;
        level_ff <= 1'b0;
        last_ff <= 1'b0;
        rise_ff <= 1'b0;
    end
    else
    begin
        meta_ff <= level_in;
        level_ff <= meta_ff;
        last_ff <= level_ff;
        // only low-to-high counts; the fall makes no event
        rise_ff <= level_ff & ~last_ff;
    end
end

endmodule

// File: rtl/usbse_epgate.v
// decides whether a host token may use the endpoint and direction it names
`timescale 1ns/1ns
module usbse_epgate
#(
    parameter NUM_EP = 7
)
(
    // clock and reset
    input wire clk,
    input wire resetn,
    // effective enables
    input wire [NUM_EP-1:0] in_en,
    input wire [NUM_EP-1:0] out_en,
    // token from the protocol engine
    input wire tok_valid,
    input wire [2:0] tok_ep,
    input wire tok_dir_in,
    // answer one cycle later
    output reg accept_ff,
    output reg refuse_ff
);

reg hit;

always @*
begin
    hit = 1'b0;
    if (tok_ep < NUM_EP)
    begin
        hit = tok_dir_in ? in_en[tok_ep] : out_en[tok_ep];
    end
end

always @(posedge clk)
begin
    if (!resetn)
    begin
        accept_ff <= 1'b0;
        refuse_ff <= 1'b0;
    end
    else
    begin
        accept_ff <= tok_valid & hit;
        refuse_ff <= tok_valid & ~hit;
    end
end

endmodule

// File: rtl/usbse_top.v
// bus state, frame timestamp, endpoint enables and interface select registers
//
// Strobed register access was decided locally.
`timescale 1ns/1ns
`include "usbse_defs.vh"
module usbse_top
#(
    parameter NUM_EP = 7,
    parameter TS_W = 11
)
(
    // clock and reset
    input wire CORE_CLK,
    input wire RESETN,
    // register port
    input wire [31:0] ADDR,
    input wire [31:0] WDATA,
    input wire WR,
    input wire RD,
    output reg [31:0] RDATA,
    // bus state levels from the line monitor
    input wire BUS_RESET_IN,
    input wire BUS_SLEEP_IN,
    // start of frame from the packet decoder, same clock
    input wire SOF_VALID,
    input wire [10:0] SOF_FRAME,
    // token check from the protocol engine, same clock
    input wire TOKEN_VALID,
    input wire [2:0] TOKEN_EP,
    input wire TOKEN_DIR_IN,
    output reg TOKEN_ACCEPT,
    output reg TOKEN_REFUSE,
    // endpoint routing to the core
    output reg [6:0] EP_IN_ENABLE,
    output reg [6:0] EP_OUT_ENABLE,
    output reg [6:0] EP_IN_INTF1,
    // events and interrupt
    output reg BUS_RESET_EVENT,
    output reg BUS_SLEEP_EVENT,
    output reg IRQ
);

// ----------------------------------------
// bus state tracking
// ----------------------------------------

wire bus_reset_flag;
wire bus_reset_rise;
wire bus_sleep_flag;
wire bus_sleep_rise;

// line levels arrive from another timing domain, hence the synchronisers
usbse_edge u_reset_edge
(
    .clk(CORE_CLK),
    .resetn(RESETN),
    .level_in(BUS_RESET_IN),
    .level_ff(bus_reset_flag),
    .rise_ff(bus_reset_rise)
);

usbse_edge u_sleep_edge
(
    .clk(CORE_CLK),
    .resetn(RESETN),
    .level_in(BUS_SLEEP_IN),
    .level_ff(bus_sleep_flag),
    .rise_ff(bus_sleep_rise)
);

// ----------------------------------------
// frame timestamp
// ----------------------------------------

reg [TS_W-1:0] frame_time_ff;
reg [TS_W-1:0] nxt_frame_time;

always @*
begin
    nxt_frame_time = frame_time_ff;
    if (SOF_VALID)
    begin
        nxt_frame_time = SOF_FRAME[TS_W-1:0];
    end
end

always @(posedge CORE_CLK)
begin
    if (!RESETN)
    begin
        frame_time_ff <= {TS_W{1'b0}};
    end
    else
    begin
        frame_time_ff <= nxt_frame_time;
    end
end

// ----------------------------------------
// register decode
// ----------------------------------------

wire sel_in_en = (ADDR == `USBSE_ADDR_IN_EN);
wire sel_out_en = (ADDR == `USBSE_ADDR_OUT_EN);
wire sel_status = (ADDR == `USBSE_ADDR_STATUS);
wire sel_intf1 = (ADDR == `USBSE_ADDR_INTF1);
wire sel_irq_stat = (ADDR == `USBSE_ADDR_IRQ_STAT);
wire sel_irq_mask = (ADDR == `USBSE_ADDR_IRQ_MASK);

// ----------------------------------------
// endpoint enables and interface select
// ----------------------------------------

// only the writable endpoint bits are stored; bit 0 is a constant one in the enables and a constant zero in the interface select
reg [NUM_EP-1:1] in_en_ff;
reg [NUM_EP-1:1] out_en_ff;
reg [NUM_EP-1:1] intf1_ep_ff;
reg intf1_gate_ff;
reg [NUM_EP-1:1] nxt_in_en;
reg [NUM_EP-1:1] nxt_out_en;
reg [NUM_EP-1:1] nxt_intf1_ep;
reg nxt_intf1_gate;
// full-width reset images, so only the stored bits are picked out below
wire [31:0] rst_in_en = `USBSE_RST_IN_EN;
wire [31:0] rst_out_en = `USBSE_RST_OUT_EN;
wire [31:0] rst_intf1 = `USBSE_RST_INTF1;

always @*
begin
    nxt_in_en = in_en_ff;
    nxt_out_en = out_en_ff;
    nxt_intf1_ep = intf1_ep_ff;
    nxt_intf1_gate = intf1_gate_ff;
    if (WR && sel_in_en)
    begin
        nxt_in_en = WDATA[`USBSE_EP_MSB:`USBSE_EP_FIRST];
    end
    if (WR && sel_out_en)
    begin
        nxt_out_en = WDATA[`USBSE_EP_MSB:`USBSE_EP_FIRST];
    end
    if (WR && sel_intf1)
    begin
        nxt_intf1_ep = WDATA[`USBSE_EP_MSB:`USBSE_EP_FIRST];
        nxt_intf1_gate = WDATA[`USBSE_INTF1_GATE_BIT];
    end
end

always @(posedge CORE_CLK)
begin
    if (!RESETN)
    begin
        in_en_ff <= rst_in_en[NUM_EP-1:1];
        out_en_ff <= rst_out_en[NUM_EP-1:1];
        intf1_ep_ff <= rst_intf1[NUM_EP-1:1];
        intf1_gate_ff <= 1'b0;
    end
    else
    begin
        in_en_ff <= nxt_in_en;
        out_en_ff <= nxt_out_en;
        intf1_ep_ff <= nxt_intf1_ep;
        intf1_gate_ff <= nxt_intf1_gate;
    end
end

wire [NUM_EP-1:0] in_en_full = {in_en_ff, 1'b1};
wire [NUM_EP-1:0] out_en_full = {out_en_ff, 1'b1};

// ----------------------------------------
// interrupt status and mask
// ----------------------------------------

reg [1:0] irq_stat_ff;
reg [1:0] irq_mask_ff;
reg [1:0] nxt_irq_stat;
reg [1:0] nxt_irq_mask;
wire [1:0] irq_set = {bus_sleep_rise, bus_reset_rise};

always @*
begin
    nxt_irq_stat = irq_stat_ff;
    nxt_irq_mask = irq_mask_ff;
    if (WR && sel_irq_stat)
    begin
        nxt_irq_stat = irq_stat_ff & ~WDATA[1:0];
    end
    // a new event in the clearing cycle is kept
    nxt_irq_stat = nxt_irq_stat | irq_set;
    if (WR && sel_irq_mask)
    begin
        nxt_irq_mask = WDATA[1:0];
    end
end

always @(posedge CORE_CLK)
begin
    if (!RESETN)
    begin
        irq_stat_ff <= `USBSE_RST_IRQ;
        irq_mask_ff <= `USBSE_RST_IRQ;
    end
    else
    begin
        irq_stat_ff <= nxt_irq_stat;
        irq_mask_ff <= nxt_irq_mask;
    end
end

// ----------------------------------------
// token gating
// ----------------------------------------

wire tok_accept;
wire tok_refuse;

// live register state is used, so a write takes effect on the next token
usbse_epgate #(.NUM_EP(NUM_EP)) u_epgate
(
    .clk(CORE_CLK),
    .resetn(RESETN),
    .in_en(in_en_full),
    .out_en(out_en_full),
    .tok_valid(TOKEN_VALID),
    .tok_ep(TOKEN_EP),
    .tok_dir_in(TOKEN_DIR_IN),
    .accept_ff(tok_accept),
    .refuse_ff(tok_refuse)
);

// ----------------------------------------
// read data
// ----------------------------------------

reg [31:0] nxt_rdata;

always @*
begin
    nxt_rdata = 32'h00000000;
    if (RD)
    begin
        if (sel_status)
        begin
            nxt_rdata[`USBSE_ST_RESET_BIT] = bus_reset_flag;
            nxt_rdata[`USBSE_ST_SLEEP_BIT] = bus_sleep_flag;
            nxt_rdata[`USBSE_ST_TS_MSB:`USBSE_ST_TS_LSB] = frame_time_ff;
            // upper bits stay zero from the default above
        end
        else if (sel_in_en)
        begin
            nxt_rdata[NUM_EP-1:0] = in_en_full;
        end
        else if (sel_out_en)
        begin
            nxt_rdata[NUM_EP-1:0] = out_en_full;
        end
        else if (sel_intf1)
        begin
            nxt_rdata[`USBSE_INTF1_GATE_BIT] = intf1_gate_ff;
            nxt_rdata[`USBSE_EP_MSB:`USBSE_EP_FIRST] = intf1_ep_ff;
        end
        else if (sel_irq_stat)
        begin
            nxt_rdata[1:0] = irq_stat_ff;
        end
        else if (sel_irq_mask)
        begin
            nxt_rdata[1:0] = irq_mask_ff;
        end
    end
end

// ----------------------------------------
// output registers
// ----------------------------------------

always @(posedge CORE_CLK)
begin
    if (!RESETN)
    begin
        RDATA <= 32'h00000000;
        TOKEN_ACCEPT <= 1'b0;
        TOKEN_REFUSE <= 1'b0;
        EP_IN_ENABLE <= 7'h01;
        EP_OUT_ENABLE <= 7'h01;
        EP_IN_INTF1 <= 7'h00;
        BUS_RESET_EVENT <= 1'b0;
        BUS_SLEEP_EVENT <= 1'b0;
        IRQ <= 1'b0;
    end
    else
    begin
        RDATA <= nxt_rdata;
        TOKEN_ACCEPT <= tok_accept;
        TOKEN_REFUSE <= tok_refuse;
        EP_IN_ENABLE <= in_en_full;
        EP_OUT_ENABLE <= out_en_full;
        // without the gate every endpoint stays on interface 0
        EP_IN_INTF1 <= intf1_gate_ff ? {intf1_ep_ff, 1'b0} : 7'h00;
        BUS_RESET_EVENT <= bus_reset_rise;
        BUS_SLEEP_EVENT <= bus_sleep_rise;
        IRQ <= |(nxt_irq_stat & nxt_irq_mask);
    end
end

endmodule

// File: test/usbse_top_properties.sv
// port assertions for the status and endpoint enable block
`timescale 1ns/1ns
module usbse_props
(
    // clock and reset
    input wire CORE_CLK,
    input wire RESETN,
    // stimulus
    input wire BUS_RESET_IN,
    input wire BUS_SLEEP_IN,
    input wire TOKEN_VALID,
    input wire [2:0] TOKEN_EP,
    // answers
    input wire TOKEN_ACCEPT,
    input wire TOKEN_REFUSE,
    input wire [6:0] EP_IN_ENABLE,
    input wire [6:0] EP_OUT_ENABLE,
    input wire [6:0] EP_IN_INTF1,
    input wire BUS_RESET_EVENT,
    input wire BUS_SLEEP_EVENT
);
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!RESETN);
    // a level must stand two cycles before the synchroniser is sure to see it
    sequence rst_rise;
        $rose(BUS_RESET_IN) ##1 BUS_RESET_IN;
    endsequence
    sequence slp_rise;
        $rose(BUS_SLEEP_IN) ##1 BUS_SLEEP_IN;
    endsequence
    ep0_in_on_a: assert property (EP_IN_ENABLE[0])
        else $error("ep0 in enable low");
    ep0_out_on_a: assert property (EP_OUT_ENABLE[0])
        else $error("ep0 out enable low");
    intf_bit0_a: assert property (!EP_IN_INTF1[0])
        else $error("ep0 mapped to second interface");
    reset_event_rise_a: assert property (rst_rise |-> ##[1:3] BUS_RESET_EVENT)
        else $error("no bus reset event after rise");
    reset_event_cause_a: assert property (BUS_RESET_EVENT |-> $past(BUS_RESET_IN, 2))
        else $error("bus reset event without rise");
    sleep_event_rise_a: assert property (slp_rise |-> ##[1:3] BUS_SLEEP_EVENT)
        else $error("no suspend event after rise");
    sleep_event_once_a: assert property (BUS_SLEEP_EVENT |=> !BUS_SLEEP_EVENT)
        else $error("suspend event longer than one cycle");
    token_ep7_refused_a: assert property (TOKEN_VALID && TOKEN_EP == 3'h7 |->
        ##2 TOKEN_REFUSE && !TOKEN_ACCEPT) else $error("endpoint 7 token not refused");
    token_ep0_taken_a: assert property (TOKEN_VALID && TOKEN_EP == 3'h0 |->
        ##2 TOKEN_ACCEPT && !TOKEN_REFUSE) else $error("endpoint 0 token not accepted");
endmodule

bind usbse_top usbse_props u_props
(
    .CORE_CLK(CORE_CLK), .RESETN(RESETN), .BUS_RESET_IN(BUS_RESET_IN),
    .BUS_SLEEP_IN(BUS_SLEEP_IN), .TOKEN_VALID(TOKEN_VALID), .TOKEN_EP(TOKEN_EP),
    .TOKEN_ACCEPT(TOKEN_ACCEPT), .TOKEN_REFUSE(TOKEN_REFUSE),
    .EP_IN_ENABLE(EP_IN_ENABLE), .EP_OUT_ENABLE(EP_OUT_ENABLE), .EP_IN_INTF1(EP_IN_INTF1),
    .BUS_RESET_EVENT(BUS_RESET_EVENT), .BUS_SLEEP_EVENT(BUS_SLEEP_EVENT)
);

// File: test/usbse_host.sv
// usb host stand-in: bus state levels, start of frame and token packets
`timescale 1ns/1ns
module usbse_host
(
    // clock
    input wire clk,
    // towards the device
    output reg bus_reset,
    output reg bus_sleep,
    output reg sof_valid,
    output reg [10:0] sof_frame,
    output reg tok_valid,
    output reg [2:0] tok_ep,
    output reg tok_dir_in
);
    initial
    begin
        {bus_reset, bus_sleep, sof_valid, tok_valid} = 4'h0;
        {sof_frame, tok_ep, tok_dir_in} = 15'h2AA5;
    end
    // packets last one cycle; fields turn to junk after, so stale use shows
    task send_sof(input [10:0] f);
    begin
        sof_valid <= 1'b1;
        sof_frame <= f;
        @(posedge clk);
        sof_valid <= 1'b0;
        sof_frame <= ~f;
    end
    endtask
    task send_token(input [2:0] ep, input dir);
    begin
        tok_valid <= 1'b1;
        tok_ep <= ep;
        tok_dir_in <= dir;
        @(posedge clk);
        tok_valid <= 1'b0;
        tok_ep <= ~ep;
        tok_dir_in <= ~dir;
    end
    endtask
    task set_levels(input r, input s);
    begin
        bus_reset <= r;
        bus_sleep <= s;
    end
    endtask
endmodule

// File: test/usbse_top_test.sv
// self-checking bench for the status and endpoint enable block
`timescale 1ns/1ns
`include "usbse_defs.vh"
module usbse_top_test;
    reg clk;
    reg resetn = 1'b0;
    reg wr = 1'b0;
    reg rd = 1'b0;
    reg [31:0] addr = 32'h0;
    reg [31:0] wdata = 32'h0;
    wire [31:0] rdata;
    wire br, bs, sv, tv, td, ta, tr, rev, sev, irq;
    wire [10:0] sf;
    wire [2:0] te;
    wire [6:0] ein, eout, eif;
    integer fail_count = 0;
    integer tests_run = 0;
    integer cyc = 0;
    integer i;
    reg [6:0] m;

    usbse_host host
    (
        .clk(clk), .bus_reset(br), .bus_sleep(bs), .sof_valid(sv), .sof_frame(sf),
        .tok_valid(tv), .tok_ep(te), .tok_dir_in(td)
    );
    usbse_top dut
    (
        .CORE_CLK(clk), .RESETN(resetn), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .BUS_RESET_IN(br), .BUS_SLEEP_IN(bs), .SOF_VALID(sv),
        .SOF_FRAME(sf), .TOKEN_VALID(tv), .TOKEN_EP(te), .TOKEN_DIR_IN(td),
        .TOKEN_ACCEPT(ta), .TOKEN_REFUSE(tr), .EP_IN_ENABLE(ein), .EP_OUT_ENABLE(eout),
        .EP_IN_INTF1(eif), .BUS_RESET_EVENT(rev), .BUS_SLEEP_EVENT(sev), .IRQ(irq)
    );

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task chk(input [31:0] got, input [31:0] exp);
    begin
        tests_run = tests_run + 1;
        if (got !== exp)
        begin
            fail_count = fail_count + 1;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    end
    endtask
    // bus tasks start on an edge and end mid-cycle so outputs have settled
    task wr_reg(input [31:0] a, input [31:0] d);
    begin
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
        @(negedge clk);
    end
    endtask
    task rd_chk(input [31:0] a, input [31:0] e);
    begin
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk(rdata, e);
    end
    endtask
    task t_reset;
    begin
        rd_chk(`USBSE_ADDR_IN_EN, 32'h1);
        rd_chk(`USBSE_ADDR_OUT_EN, 32'h1);
        rd_chk(`USBSE_ADDR_STATUS, 32'h0);
        rd_chk(`USBSE_ADDR_INTF1, 32'h0);
    end
    endtask
    task t_en;
    begin
        wr_reg(`USBSE_ADDR_IN_EN, 32'hFFFFFF0A);
        wr_reg(`USBSE_ADDR_OUT_EN, 32'h00000054);
        wr_reg(32'h40011078, 32'hFFFFFFFF);
        rd_chk(`USBSE_ADDR_IN_EN, 32'hB);
        rd_chk(`USBSE_ADDR_OUT_EN, 32'h55);
        rd_chk(32'h40011078, 32'h0);
        chk(eout, 32'h55);
        chk(ein, 32'hB);
    end
    endtask
    task t_tok;
    begin
        for (i = 0; i < 16; i = i + 1)
        begin
            @(posedge clk);
            host.send_token(i[2:0], i[3]);
            @(posedge clk);
            @(negedge clk);
            m = i[3] ? 7'h0B : 7'h55;
            chk({tr, ta}, (i[2:0] != 3'h7 && m[i[2:0]]) ? 2'b01 : 2'b10);
        end
    end
    endtask
    task t_intf;
    begin
        wr_reg(`USBSE_ADDR_INTF1, 32'h0000007F);
        rd_chk(`USBSE_ADDR_INTF1, 32'h7E);
        chk(eif, 32'h0);
        wr_reg(`USBSE_ADDR_INTF1, 32'h8000000C);
        chk(eif, 32'hC);
        rd_chk(`USBSE_ADDR_INTF1, 32'h8000000C);
    end
    endtask
    task t_ev;
    begin
        wr_reg(`USBSE_ADDR_IRQ_MASK, 32'h1);
        @(posedge clk);
        host.set_levels(1'b1, 1'b0);
        for (i = 0; i < 8 && rev !== 1'b1; i = i + 1)
            @(negedge clk);
        chk({rev, irq}, 2'b11);
        rd_chk(`USBSE_ADDR_STATUS, 32'h1000);
        rd_chk(`USBSE_ADDR_IRQ_MASK, 32'h1);
        @(posedge clk);
        host.set_levels(1'b0, 1'b1);
        for (i = 0; i < 8 && sev !== 1'b1; i = i + 1)
            @(negedge clk);
        chk({sev, rev}, 2'b10);
        rd_chk(`USBSE_ADDR_STATUS, 32'h800);
        rd_chk(`USBSE_ADDR_IRQ_STAT, 32'h3);
        wr_reg(`USBSE_ADDR_IRQ_STAT, 32'h1);
        chk(irq, 1'b0);
        wr_reg(`USBSE_ADDR_IRQ_MASK, 32'h3);
        chk(irq, 1'b1);
        @(posedge clk);
        host.set_levels(1'b0, 1'b0);
        rd_chk(`USBSE_ADDR_IRQ_STAT, 32'h2);
        rd_chk(`USBSE_ADDR_STATUS, 32'h0);
        wr_reg(`USBSE_ADDR_IRQ_STAT, 32'h2);
        chk(irq, 1'b0);
    end
    endtask
    task t_sof;
    begin
        @(posedge clk);
        host.send_sof(11'h7FF);
        rd_chk(`USBSE_ADDR_STATUS, 32'h7FF);
        @(posedge clk);
        host.send_sof(11'h123);
        rd_chk(`USBSE_ADDR_STATUS, 32'h123);
    end
    endtask
    task final_report;
    begin
        if (fail_count == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    end
    endtask

    // run takes under two hundred cycles; the ceiling leaves ample slack
    always @(posedge clk)
    begin
        cyc = cyc + 1;
        if (cyc == 3000)
        begin
            fail_count = fail_count + 1;
            final_report;
        end
    end

    initial
    begin
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        t_reset;
        t_en;
        t_tok;
        t_intf;
        t_ev;
        t_sof;
        final_report;
    end
endmodule
